// File: hw/i2cssf_pkg.sv
// package for the start condition filter: register address, fields, resets
// assumes an 8-bit special-function register port and a 125 MHz oscillator clock
package i2cssf_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] SETUP_ADDR = 8'hDB;
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam int EN_BIT = 7;
	localparam int CNT_MSB = 6;
	localparam int CNT_WIDTH = 7;
	localparam logic [1:0] SYNC_RESET = 2'h3;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] ONE_SAMPLE = 8'h01;
	// ****************************************
	// filter states
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_ADDR
	} i2cssf_state_type;
endpackage

// File: hw/i2cssf_sync.sv
// two-stage synchroniser for one bus line
// assumes the line is asynchronous to i_clk and idles high
`timescale 1ns/1ps
module i2cssf_sync
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_line,
	output logic o_line
);
	logic [1:0] sync_ff;

	// ****************************************
	// first stage feeds only the second
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			sync_ff <= i2cssf_pkg::SYNC_RESET;
		else
			sync_ff <= {sync_ff[0], i_line};
	end

	assign o_line = sync_ff[1];
endmodule // i2cssf_sync

// File: hw/i2cssf_filter.sv
// start condition noise filter for the serial io engine slave side
// assumes sda and scl arrive as raw pin levels; sfr port on i_clk
//
// Operation
// - sda fall while scl high starts candidate
// - every sample needs sda low, scl high
// - validated start begins address byte reception
// - enable clear: single sample, count ignored
// - enable set: count plus one samples
// - samples one clock apart, first after edge
// - setup register at DBh, reset 00h
`timescale 1ns/1ps
module i2cssf_filter
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_sda,
	input wire logic i_scl,
	input wire logic i_slave_mode,
	input wire logic i_addr_done,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	output logic o_start_valid,
	output logic o_start_reject,
	output logic o_addr_rx
);
	logic sda_s;
	logic scl_s;
	logic sda_d_ff;
	logic [7:0] setup_ff;
	logic [7:0] count_ff;
	logic [7:0] nxt_count;
	i2cssf_pkg::i2cssf_state_type state_ff;
	i2cssf_pkg::i2cssf_state_type nxt_state;
	logic fall_edge;
	logic sample_ok;
	logic nxt_valid;
	logic nxt_reject;
	logic [7:0] load_count;
	logic [1:0] pin_raw;
	logic [1:0] pin_s;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// bit 0 carries sda, bit 1 carries scl
	assign pin_raw = {i_scl, i_sda};

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_pin_sync
			i2cssf_sync i2cssf_sync_i
			(
				.i_clk(i_clk),
				.i_rst_b(i_rst_b),
				.i_line(pin_raw[g]),
				.o_line(pin_s[g])
			);
		end
	endgenerate

	assign sda_s = pin_s[0];
	assign scl_s = pin_s[1];

	// ****************************************
	// edge detector and sample levels
	// ****************************************

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			sda_d_ff <= 1'h1;
		else
			sda_d_ff <= sda_s;
	end

	assign fall_edge = sda_d_ff && !sda_s && scl_s;
	assign sample_ok = !sda_s && scl_s;

	// ****************************************
	// sample count loaded at each candidate
	// ****************************************
	always_comb
	begin
		// enable clear takes one sample
		if (setup_ff[i2cssf_pkg::EN_BIT])
			load_count = {1'h0, setup_ff[i2cssf_pkg::CNT_MSB:0]}
				+ i2cssf_pkg::ONE_SAMPLE;
		else
			load_count = i2cssf_pkg::ONE_SAMPLE;
	end

	// ****************************************
	// setup register
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			setup_ff <= i2cssf_pkg::SETUP_RESET;
		else if (i_sfr_wr && i_sfr_addr == i2cssf_pkg::SETUP_ADDR)
			setup_ff <= i_sfr_wdata;
	end

	// ****************************************
	// register read port
	// ****************************************

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_sfr_rdata <= 8'h00;
		else if (i_sfr_rd && i_sfr_addr == i2cssf_pkg::SETUP_ADDR)
			o_sfr_rdata <= setup_ff;
		else
			o_sfr_rdata <= 8'h00;
	end

	// ****************************************
	// sampling state machine
	// ****************************************
	always_comb
	begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_valid = 1'h0;
		nxt_reject = 1'h0;
		case (state_ff)
			i2cssf_pkg::ST_IDLE:
			begin
				if (i_slave_mode && fall_edge)
				begin
					// falls are ignored outside idle
					nxt_state = i2cssf_pkg::ST_SAMPLE;
					nxt_count = load_count;
				end
			end
			i2cssf_pkg::ST_SAMPLE:
			begin
				// one sample per clock, first one after the edge
				if (!sample_ok)
				begin
					nxt_state = i2cssf_pkg::ST_IDLE;
					nxt_reject = 1'h1;
				end
				else if (count_ff == i2cssf_pkg::ONE_SAMPLE)
				begin
					nxt_state = i2cssf_pkg::ST_ADDR;
					nxt_valid = 1'h1;
				end
				else
					nxt_count = count_ff - i2cssf_pkg::ONE_SAMPLE;
			end
			i2cssf_pkg::ST_ADDR:
			begin
				// receiver done or mode change ends the phase
				if (i_addr_done || !i_slave_mode)
					nxt_state = i2cssf_pkg::ST_IDLE;
			end
			default:
				nxt_state = i2cssf_pkg::ST_IDLE;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			state_ff <= i2cssf_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ****************************************
	// sample down-counter
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			count_ff <= i2cssf_pkg::COUNT_RESET;
		else
			count_ff <= nxt_count;
	end

	// ****************************************
	// result strobes, one cycle each
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_start_valid <= 1'h0;
		else
			o_start_valid <= nxt_valid;
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_start_reject <= 1'h0;
		else
			o_start_reject <= nxt_reject;
	end

	// ****************************************
	// address phase flag
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		// address flag follows the next state
		if (!i_rst_b)
			o_addr_rx <= 1'h0;
		else
			o_addr_rx <= (nxt_state == i2cssf_pkg::ST_ADDR);
	end
endmodule // i2cssf_filter

// File: dv/i2cssf_master.sv
// bus master model making start conditions
// assumes the filter samples the pins on i_clk
`timescale 1ns/1ps
module i2cssf_master(input wire logic i_clk,output logic o_sda,
output logic o_scl);
initial {o_sda,o_scl}=2'b11; // pulled-up lines idle high
task automatic start_cond(input int hold,input int cut);
@(negedge i_clk) o_sda=0;
for(int k=1;k<=hold;k++)
begin
@(negedge i_clk) o_scl=(k!=cut);
end
o_scl=0;
repeat(5) @(negedge i_clk);
o_sda=1;
repeat(5) @(negedge i_clk);
o_scl=1;
endtask
endmodule // i2cssf_master

// File: dv/i2cssf_chk.sv
// assertions on the filter ports
// assumes one clock domain on i_clk
`timescale 1ns/1ps
module i2cssf_chk(input wire logic i_clk,i_rst_b,i_sda,i_scl,i_sfr_wr,
input wire logic i_sfr_rd,i_addr_done,i_slave_mode,o_start_valid,
input wire logic o_start_reject,o_addr_rx,
input wire logic [7:0] i_sfr_addr,i_sfr_wdata,o_sfr_rdata);
logic [7:0] r_ff;
always_ff @(posedge i_clk or negedge i_rst_b)
if(!i_rst_b) r_ff<=8'h00;
else if(i_sfr_wr&&i_sfr_addr==8'hDB) r_ff<=i_sfr_wdata;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_b);
one_verdict_a: assert property(!(o_start_valid&&o_start_reject))
else $error("both strobes");
valid_pulse_a: assert property(o_start_valid|=>!o_start_valid)
else $error("long valid");
reject_pulse_a: assert property(o_start_reject|=>!o_start_reject)
else $error("long reject");
valid_addr_a: assert property(o_start_valid|->o_addr_rx)
else $error("no addr");
valid_lines_a: assert property($rose(o_start_valid)|->
$past(i_scl,3)&&!$past(i_sda,3)) else $error("bad lines");
addr_hold_a: assert property($fell(o_addr_rx)|->
$past(i_addr_done)||!$past(i_slave_mode)) else $error("addr drop");
rd_idle_a: assert property(!$past(i_sfr_rd)|->o_sfr_rdata==8'h00)
else $error("rdata set");
rd_value_a: assert property(i_sfr_rd&&!i_sfr_wr&&i_sfr_addr==8'hDB
|=>o_sfr_rdata==r_ff) else $error("rdata bad");
cover property(o_start_valid);
cover property(o_start_reject);
cover property(i_sfr_rd&&i_sfr_addr==8'hDB);
endmodule // i2cssf_chk
bind i2cssf_filter i2cssf_chk i2cssf_chk_i(.*);

// File: dv/i2c_start_condition_filter_tb_top.sv
// bench for the start filter
// assumes the master model drives the bus pins
`timescale 1ns/1ps
`define CHK(a,b) begin n_checks++; if((a)!==(b)) begin n_mismatch++; \
$display("unexpected %0t %0h %0h",$time,a,b); end end
module i2c_start_condition_filter_tb_top;
logic i_clk=0,i_rst_b=0,i_sda,i_scl,i_slave_mode=1,i_addr_done=0;
logic i_sfr_wr=0,i_sfr_rd=0,o_start_valid,o_start_reject,o_addr_rx,v,rj;
logic [7:0] i_sfr_addr=8'h00,i_sfr_wdata=8'h00,o_sfr_rdata,d;
int n_mismatch,n_checks,cyc,l0,l;
always #4 i_clk=~i_clk;
i2cssf_filter i2cssf_filter_i(.*);
i2cssf_master i2cssf_master_i(.i_clk,.o_sda(i_sda),.o_scl(i_scl));
task print_verdict;
$display("mismatches %0d checks %0d",n_mismatch,n_checks);
if(n_mismatch==0&&n_checks>0) $display("No errors found");
else $display("Errors were found");
$finish;
endtask
task wr(input logic [7:0] a,w);
@(negedge i_clk);
{i_sfr_addr,i_sfr_wdata,i_sfr_wr}={a,w,1'b1};
@(negedge i_clk) i_sfr_wr=0;
endtask
task rd(input logic [7:0] a);
@(negedge i_clk) {i_sfr_addr,i_sfr_rd}={a,1'b1};
@(negedge i_clk);
i_sfr_rd=0;
d=o_sfr_rdata;
endtask
task run(input logic [7:0] s,input int cut);
wr(8'hDB,s);
l=0;
fork
i2cssf_master_i.start_cond(140,cut);
begin
while(!o_start_valid&&!o_start_reject&&l<200)
begin
@(negedge i_clk) l++;
end
v=o_start_valid;
rj=o_start_reject;
`CHK(o_addr_rx,v)
end
join
@(negedge i_clk) i_addr_done=1;
@(negedge i_clk) i_addr_done=0;
$display("test %0h done",s);
endtask
always @(negedge i_clk)
begin
cyc++;
if(cyc>3000)
begin
n_mismatch++;
print_verdict;
end
end
initial
begin
repeat(2) @(negedge i_clk);
i_rst_b=1;
rd(8'hDB); `CHK(d,8'h00)
wr(8'hDA,8'h55); rd(8'hDA); `CHK(d,8'h00)
run(8'h00,0); l0=l; `CHK(v,1'b1)
run(8'h7F,0); `CHK(l,l0)
run(8'h81,0); `CHK(l,l0+1)
run(8'hFF,0); `CHK(l,l0+127)
rd(8'hDB); `CHK(d,8'hFF)
run(8'h8B,6); `CHK(v,1'b0)
`CHK(rj,1'b1)
run(8'h8B,30); `CHK(l,l0+11)
i_slave_mode=0;
run(8'h00,0); `CHK(l,200)
i_slave_mode=1;
print_verdict;
end
endmodule // i2c_start_condition_filter_tb_top
